// ==== fcl_loader.sv ====
// Configuration loader: flash master, link slave, ROM source
`timescale 1ns/1ps
module fcl_loader
#(
	parameter int CFG_WORDS = 1024
)
(
	// System
	input  wire logic        i_sys_clk,
	input  wire logic        i_rstn,
	// Configuration pins
	input  wire logic        i_config_reset_n,
	input  wire logic [1:0]  i_mode,
	input  wire logic [2:0]  i_width,
	// Serial flash
	output logic             o_spi_sck,
	output logic             o_spi_cs_n,
	output logic             o_spi_mosi,
	input  wire logic [3:0]  i_spi_dq,
	// Passive and JTAG link
	input  wire logic        i_link_clk,
	input  wire logic        i_link_en,
	input  wire logic [31:0] i_link_data,
	output logic             o_link_ready,
	// User side
	output logic             o_cfg_done,
	output logic             o_cfg_busy,
	input  wire logic [9:0]  i_cfg_rd_addr,
	output logic [31:0]      o_cfg_rd_data
);
	//************************************************************
	// Declarations
	//************************************************************
	fcl_mem_if mif ();
	fcl_pkg::fcl_state_t state_ff, nxt_state;
	logic [1:0]  crst_sync_ff, mode_m_ff, mode_s_ff, dq_lo_ff;
	logic [2:0]  width_m_ff, width_s_ff, wcode_ff;
	logic [3:0]  dq_m_ff, dq_s_ff;
	logic        crst_d_ff, start;
	logic [1:0]  phase_ff;
	logic [5:0]  bits_ff;
	logic [8:0]  wait_ff;
	logic [31:0] tx_ff, rsh_ff, nxt_rsh;
	logic [5:0]  rcnt_ff, nxt_rcnt;
	logic [10:0] wcnt_ff;
	logic        wr_en_ff;
	logic [31:0] wr_data_ff;
	logic        sck_ff, cs_n_ff, mosi_ff, done_ff, busy_ff;
	logic        arm_ff, ack_ff, req_m_ff, req_s_ff;
	logic        per_end, shifting;
	// Link domain
	logic        arm_m_ff, arm_s_ff, ack_m_ff, ack_s_ff;
	logic [2:0]  lw_m_ff, lw_s_ff;
	logic [31:0] lsh_ff, hold_ff, nxt_lsh;
	logic [5:0]  lcnt_ff, nxt_lcnt;
	logic        req_ff, ready_ff, pend, accept;

	//************************************************************
	// Pin synchronisers
	//************************************************************
	// Two flops on every strap, reset and flash data pin; stage one feeds stage two only
	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			crst_sync_ff <= 2'h3; // Idle high, as the pulled-up pin
			mode_m_ff    <= 2'h0;
			mode_s_ff    <= 2'h0;
			width_m_ff   <= 3'h0;
			width_s_ff   <= 3'h0;
			dq_m_ff      <= 4'h0;
			dq_s_ff      <= 4'h0;
			req_m_ff     <= 1'b0;
			req_s_ff     <= 1'b0;
			crst_d_ff    <= 1'b1; // No false start after reset
		end
		else
		begin
			crst_sync_ff <= {crst_sync_ff[0], i_config_reset_n};
			mode_m_ff    <= i_mode;
			mode_s_ff    <= mode_m_ff;
			width_m_ff   <= i_width;
			width_s_ff   <= width_m_ff;
			dq_m_ff      <= i_spi_dq;
			dq_s_ff      <= dq_m_ff;
			req_m_ff     <= req_ff;
			req_s_ff     <= req_m_ff;
			crst_d_ff    <= crst_sync_ff[1];
		end
	end

	// Rising edge of config reset starts a load
	assign start = crst_sync_ff[1] & ~crst_d_ff;
	assign dq_lo_ff = dq_s_ff[1:0];

	//************************************************************
	// Strap capture at start
	//************************************************************
	// Width latched on the start edge only
	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			wcode_ff <= fcl_pkg::W_X1;
		end
		else if (start)
		begin
			// Active clamps to x4, JTAG forced to x1
			if (mode_s_ff == 2'(fcl_pkg::MODE_JTAG))
				wcode_ff <= fcl_pkg::W_X1;
			else if (mode_s_ff == 2'(fcl_pkg::MODE_ACTIVE)
				&& width_s_ff > fcl_pkg::W_X4)
				wcode_ff <= fcl_pkg::W_X4;
			else if (width_s_ff > fcl_pkg::W_X32)
				wcode_ff <= fcl_pkg::W_X32;
			else
				wcode_ff <= width_s_ff;
		end
	end

	//************************************************************
	// Load sequencer
	//************************************************************
	assign per_end  = (phase_ff == fcl_pkg::PH_LAST);
	assign shifting = (state_ff == fcl_pkg::ST_WAKE)
		|| (state_ff == fcl_pkg::ST_CMD)
		|| (state_ff == fcl_pkg::ST_DUMMY)
		|| (state_ff == fcl_pkg::ST_READ);

	// Next state
	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			fcl_pkg::ST_IDLE:  nxt_state = state_ff;
			fcl_pkg::ST_WAKE:
				if (per_end && bits_ff == 6'h01)
					nxt_state = fcl_pkg::ST_WAIT;
			fcl_pkg::ST_WAIT:
				if (wait_ff == 9'h001)
					nxt_state = fcl_pkg::ST_CMD;
			fcl_pkg::ST_CMD:
				if (per_end && bits_ff == 6'h01)
					nxt_state = fcl_pkg::ST_DUMMY;
			fcl_pkg::ST_DUMMY:
				if (per_end && bits_ff == 6'h01)
					nxt_state = fcl_pkg::ST_READ;
			fcl_pkg::ST_READ, fcl_pkg::ST_LINK, fcl_pkg::ST_ROM:
				if (wcnt_ff == 11'(CFG_WORDS))
					nxt_state = fcl_pkg::ST_DONE;
			fcl_pkg::ST_DONE:  nxt_state = state_ff;
			default:           nxt_state = fcl_pkg::ST_IDLE;
		endcase
		// Low level aborts, rising edge restarts
		if (!crst_sync_ff[1])
			nxt_state = fcl_pkg::ST_IDLE;
		else if (start)
			case (fcl_pkg::fcl_mode_t'(mode_s_ff))
				fcl_pkg::MODE_ACTIVE: nxt_state = fcl_pkg::ST_WAKE;
				fcl_pkg::MODE_ROM:    nxt_state = fcl_pkg::ST_ROM;
				default:              nxt_state = fcl_pkg::ST_LINK;
			endcase
	end

	// State register
	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			state_ff <= fcl_pkg::ST_IDLE;
		else
			state_ff <= nxt_state;
	end

	// Clock phase, bit and wait counters; clock from own divider
	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			phase_ff <= 2'h0;
			bits_ff  <= 6'h0;
			wait_ff  <= 9'h0;
			tx_ff    <= fcl_pkg::WORD_RST;
		end
		else if (nxt_state != state_ff)
		begin
			phase_ff <= 2'h0;
			wait_ff  <= 9'(fcl_pkg::WAKE_WAIT_CYC);
			case (nxt_state)
				fcl_pkg::ST_WAKE:
				begin
					bits_ff <= fcl_pkg::WAKE_BITS;
					tx_ff   <= {fcl_pkg::CMD_WAKE, 24'h000000};
				end
				fcl_pkg::ST_CMD:
				begin
					bits_ff <= fcl_pkg::CMD_BITS;
					tx_ff   <= {fcl_pkg::CMD_FAST_READ,
						fcl_pkg::START_ADDR};
				end
				default:
				begin
					bits_ff <= fcl_pkg::DUMMY_CLKS;
					tx_ff   <= fcl_pkg::WORD_RST;
				end
			endcase
		end
		else
		begin
			phase_ff <= phase_ff + 2'h1;
			if (wait_ff != 9'h0)
				wait_ff <= wait_ff - 9'h1;
			if (per_end && bits_ff != 6'h0)
			begin
				bits_ff <= bits_ff - 6'h1;
				tx_ff   <= {tx_ff[30:0], 1'b0};
			end
		end
	end

	//************************************************************
	// Serial flash pins
	//************************************************************
	// Clock high in phases 2-3, data changes in phase 1
	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			sck_ff  <= 1'b0;
			cs_n_ff <= 1'b1;
			mosi_ff <= 1'b0;
		end
		else
		begin
			sck_ff  <= shifting && (nxt_state == state_ff)
				&& (phase_ff == 2'h1 || phase_ff == 2'h2);
			cs_n_ff <= !(shifting && nxt_state != fcl_pkg::ST_WAIT
				&& nxt_state != fcl_pkg::ST_IDLE);
			mosi_ff <= tx_ff[31];
		end
	end

	//************************************************************
	// Word assembly and memory write
	//************************************************************
	// Shift in sampled flash bits at the period end
	always_comb
	begin
		nxt_rsh  = rsh_ff;
		nxt_rcnt = rcnt_ff;
		case (wcode_ff)
			fcl_pkg::W_X2:
			begin
				nxt_rsh  = {rsh_ff[29:0], dq_lo_ff};
				nxt_rcnt = rcnt_ff + 6'h02;
			end
			fcl_pkg::W_X4:
			begin
				nxt_rsh  = {rsh_ff[27:0], dq_s_ff};
				nxt_rcnt = rcnt_ff + 6'h04;
			end
			default:
			begin
				nxt_rsh  = {rsh_ff[30:0], dq_s_ff[1]};
				nxt_rcnt = rcnt_ff + 6'h01;
			end
		endcase
	end

	// Memory writes from flash, link and ROM sources
	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			rsh_ff     <= fcl_pkg::WORD_RST;
			rcnt_ff    <= 6'h0;
			wcnt_ff    <= 11'h0;
			wr_en_ff   <= 1'b0;
			wr_data_ff <= fcl_pkg::WORD_RST;
			ack_ff     <= 1'b0;
		end
		else
		begin
			wr_en_ff <= 1'b0;
			// Stale link words are discarded outside a link load
			if (req_s_ff != ack_ff)
			begin
				ack_ff <= ~ack_ff;
				if (state_ff == fcl_pkg::ST_LINK && !wr_en_ff)
				begin
					wr_en_ff   <= 1'b1;
					wr_data_ff <= hold_ff;
				end
			end
			if (start)
			begin
				rsh_ff  <= fcl_pkg::WORD_RST;
				rcnt_ff <= 6'h0;
				wcnt_ff <= 11'h0;
			end
			else if (wr_en_ff)
				wcnt_ff <= wcnt_ff + 11'h1;
			else if (state_ff == fcl_pkg::ST_ROM
				&& wcnt_ff != 11'(CFG_WORDS))
			begin
				wr_en_ff   <= 1'b1;
				wr_data_ff <= fcl_pkg::ROM_FILL ^ {21'h0, wcnt_ff};
			end
			else if (state_ff == fcl_pkg::ST_READ && per_end
				&& wcnt_ff != 11'(CFG_WORDS))
			begin
				rsh_ff  <= nxt_rsh;
				rcnt_ff <= (nxt_rcnt == 6'h20) ? 6'h0 : nxt_rcnt;
				if (nxt_rcnt == 6'h20)
				begin
					wr_en_ff   <= 1'b1;
					wr_data_ff <= nxt_rsh;
				end
			end
		end
	end

	assign mif.wr_en   = wr_en_ff;
	assign mif.wr_addr = wcnt_ff[9:0];
	assign mif.wr_data = wr_data_ff;
	assign mif.rd_addr = i_cfg_rd_addr;

	// Status flags and link arm level
	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			done_ff <= 1'b0;
			busy_ff <= 1'b0;
			arm_ff  <= 1'b0;
		end
		else
		begin
			done_ff <= (nxt_state == fcl_pkg::ST_DONE);
			busy_ff <= (nxt_state != fcl_pkg::ST_DONE)
				&& (nxt_state != fcl_pkg::ST_IDLE);
			// Arm follows the state, so the width code is settled
			arm_ff  <= (state_ff == fcl_pkg::ST_LINK);
		end
	end

	//************************************************************
	// Link domain: passive and JTAG receiver
	//************************************************************
	// Arm, width and ack cross in by two flops
	always_ff @(posedge i_link_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			arm_m_ff <= 1'b0;
			arm_s_ff <= 1'b0;
			lw_m_ff  <= 3'h0;
			lw_s_ff  <= 3'h0;
			ack_m_ff <= 1'b0;
			ack_s_ff <= 1'b0;
		end
		else
		begin
			arm_m_ff <= arm_ff;
			arm_s_ff <= arm_m_ff;
			lw_m_ff  <= wcode_ff;
			lw_s_ff  <= lw_m_ff;
			ack_m_ff <= ack_ff;
			ack_s_ff <= ack_m_ff;
		end
	end

	assign pend   = req_ff != ack_s_ff;
	assign accept = i_link_en && ready_ff;

	// Shift by the strapped width, x1 up to x32
	always_comb
	begin
		nxt_lsh  = {lsh_ff[30:0], i_link_data[0]};
		nxt_lcnt = lcnt_ff + 6'h01;
		case (lw_s_ff)
			fcl_pkg::W_X2:
			begin
				nxt_lsh  = {lsh_ff[29:0], i_link_data[1:0]};
				nxt_lcnt = lcnt_ff + 6'h02;
			end
			fcl_pkg::W_X4:
			begin
				nxt_lsh  = {lsh_ff[27:0], i_link_data[3:0]};
				nxt_lcnt = lcnt_ff + 6'h04;
			end
			fcl_pkg::W_X8:
			begin
				nxt_lsh  = {lsh_ff[23:0], i_link_data[7:0]};
				nxt_lcnt = lcnt_ff + 6'h08;
			end
			fcl_pkg::W_X16:
			begin
				nxt_lsh  = {lsh_ff[15:0], i_link_data[15:0]};
				nxt_lcnt = lcnt_ff + 6'h10;
			end
			fcl_pkg::W_X32:
			begin
				nxt_lsh  = i_link_data;
				nxt_lcnt = 6'h20;
			end
			default: ;
		endcase
	end

	// Word held stable until the system side acknowledges
	always_ff @(posedge i_link_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			lsh_ff   <= fcl_pkg::WORD_RST;
			lcnt_ff  <= 6'h0;
			hold_ff  <= fcl_pkg::WORD_RST;
			req_ff   <= 1'b0;
			ready_ff <= 1'b0;
		end
		else
		begin
			ready_ff <= arm_s_ff && !pend
				&& !(accept && nxt_lcnt == 6'h20);
			if (!arm_s_ff)
			begin
				lsh_ff  <= fcl_pkg::WORD_RST;
				lcnt_ff <= 6'h0;
			end
			else if (accept)
			begin
				lsh_ff <= nxt_lsh;
				if (nxt_lcnt == 6'h20)
				begin
					lcnt_ff <= 6'h0;
					hold_ff <= nxt_lsh;
					req_ff  <= ~req_ff;
				end
				else
					lcnt_ff <= nxt_lcnt;
			end
		end
	end

	//************************************************************
	// Memory and outputs
	//************************************************************
	fcl_cfg_mem u_mem
	(
		.i_sys_clk (i_sys_clk),
		.m         (mif.mem)
	);

	assign o_spi_sck     = sck_ff;
	assign o_spi_cs_n    = cs_n_ff;
	assign o_spi_mosi    = mosi_ff;
	assign o_link_ready  = ready_ff;
	assign o_cfg_done    = done_ff;
	assign o_cfg_busy    = busy_ff;
	assign o_cfg_rd_data = mif.rd_data;
endmodule // fcl_loader

// ==== fcl_pkg.sv ====
// Package of constants and types for the configuration loader
//****************************************************************
// Contract
//****************************************************************
// Contract
// - Reset rising edge starts serial flash load
// - Active mode clock comes from own clock
// - First flash transaction is release power-down
// - Wait at least 30 us before read
// - Fast read from start address zero
// - Widths: active x1/x2/x4, passive up to x32
// - JTAG loading is a third mode, x1
// - No user mode before memory is loaded
// - Received bitstream is written into config memory
// - Mask ROM option replaces the external flash
package fcl_pkg;

	//************************************************************
	// Memory geometry
	//************************************************************
	localparam int MEM_DEPTH = 1024;
	localparam int MEM_AW    = 10;
	localparam int WORD_W    = 32;

	//************************************************************
	// Flash command set and timing
	//************************************************************
	localparam logic [7:0]  CMD_WAKE      = 8'hAB;
	localparam logic [7:0]  CMD_FAST_READ = 8'h0B;
	localparam logic [23:0] START_ADDR    = 24'h000000;
	localparam logic [5:0]  WAKE_BITS     = 6'h08;
	localparam logic [5:0]  CMD_BITS      = 6'h20;
	localparam logic [5:0]  DUMMY_CLKS    = 6'h08;
	localparam int SYS_PERIOD_NS = 100;
	localparam int WAKE_WAIT_NS  = 30000;
	localparam int WAKE_WAIT_CYC =
		(WAKE_WAIT_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
	localparam logic [1:0]  PH_LAST       = 2'h3;

	//************************************************************
	// Width codes
	//************************************************************
	localparam logic [2:0] W_X1  = 3'h0;
	localparam logic [2:0] W_X2  = 3'h1;
	localparam logic [2:0] W_X4  = 3'h2;
	localparam logic [2:0] W_X8  = 3'h3;
	localparam logic [2:0] W_X16 = 3'h4;
	localparam logic [2:0] W_X32 = 3'h5;

	//************************************************************
	// Mask ROM contents and reset values
	//************************************************************
	localparam logic [31:0] ROM_FILL  = 32'h5A3C_96E1; // Arbitrary
	localparam logic [31:0] WORD_RST  = 32'h0000_0000;

	typedef enum logic [1:0]
	{
		MODE_ACTIVE,
		MODE_PASSIVE,
		MODE_JTAG,
		MODE_ROM
	} fcl_mode_t;

	typedef enum logic [3:0]
	{
		ST_IDLE,
		ST_WAKE,
		ST_WAIT,
		ST_CMD,
		ST_DUMMY,
		ST_READ,
		ST_LINK,
		ST_ROM,
		ST_DONE
	} fcl_state_t;

endpackage

// ==== fcl_mem_if.sv ====
// Interface joining the loader to its configuration memory
`timescale 1ns/1ps
interface fcl_mem_if;
	logic                      wr_en;
	logic [fcl_pkg::MEM_AW-1:0] wr_addr;
	logic [fcl_pkg::WORD_W-1:0] wr_data;
	logic [fcl_pkg::MEM_AW-1:0] rd_addr;
	logic [fcl_pkg::WORD_W-1:0] rd_data;

	modport ctl (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
	modport mem (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface

// ==== fcl_cfg_mem.sv ====
// Configuration memory with registered read port
`timescale 1ns/1ps
module fcl_cfg_mem
(
	// Clock
	input  wire logic i_sys_clk,
	// Access
	fcl_mem_if.mem    m
);
	logic [fcl_pkg::WORD_W-1:0] mem_q [0:fcl_pkg::MEM_DEPTH-1];
	logic [fcl_pkg::WORD_W-1:0] rd_ff;

	// Write port
	always_ff @(posedge i_sys_clk)
	begin
		if (m.wr_en)
			mem_q[m.wr_addr] <= m.wr_data;
	end

	// Registered read port
	always_ff @(posedge i_sys_clk)
	begin
		rd_ff <= mem_q[m.rd_addr];
	end

	assign m.rd_data = rd_ff;
endmodule // fcl_cfg_mem

// ==== fcl_flash_model.sv ====
// Behavioural serial flash standing at the far side of the loader
`timescale 1ns/1ps
module fcl_flash_model
(
	// Flash pins
	input  wire logic        i_sck,
	input  wire logic        i_cs_n,
	input  wire logic        i_mosi,
	output logic [3:0]       o_dq,
	// Bench side
	input  wire logic [2:0]  i_wc,
	output logic [7:0]       o_wake,
	output logic [31:0]      o_rcmd,
	output logic [31:0]      o_gap
);
	int          n, p, w;
	logic [31:0] sh, t_end, wd;

	// Flash contents, one word per index
	function automatic logic [31:0] fw(input int k);
		return {4{k[7:0]}} ^ 32'hA5C3_0F96;
	endfunction

	initial
	begin
		n = 0; sh = 32'h0; t_end = 32'h0; o_dq = 4'h0;
		o_wake = 8'h00; o_rcmd = 32'h0; o_gap = 32'h0;
	end

	// New frame: note the idle time before it
	always @(negedge i_cs_n)
	begin
		n = 0;
		o_gap = 32'($time) - t_end;
	end

	// Frame end: keep a short command, let the lines wander
	always @(posedge i_cs_n)
	begin
		if (n == 8)
		begin
			o_wake = sh[7:0];
			t_end = 32'($time);
		end
		o_dq = ~o_dq;
	end

	// Command and address shift in on the rising clock
	always @(posedge i_sck)
		if (!i_cs_n)
		begin
			if (n < 32)
				sh = {sh[30:0], i_mosi};
			if (n == 31)
				o_rcmd = sh;
			n++;
		end

	// Data leaves on the falling clock after the dummies
	always @(negedge i_sck)
	begin
		o_dq = ~o_dq; // Unused lines keep changing
		if (!i_cs_n && n >= 40)
		begin
			w = 1 << i_wc;
			p = (n - 40) * w;
			wd = fw(p / 32) << (p % 32);
			if (w == 4)
				o_dq = wd[31:28];
			else if (w == 2)
				o_dq[1:0] = wd[31:30];
			else
				o_dq[1] = wd[31];
		end
	end
endmodule // fcl_flash_model

// ==== fcl_loader_sva.sv ====
// Checker on the loader's pins
`timescale 1ns/1ps
module fcl_loader_chk
#(
	parameter int CFG_WORDS = 1024
)
(
	// System and straps
	input wire logic        i_sys_clk,
	input wire logic        i_rstn,
	input wire logic        i_config_reset_n,
	input wire logic [1:0]  i_mode,
	input wire logic [2:0]  i_width,
	// Flash
	input wire logic        o_spi_sck,
	input wire logic        o_spi_cs_n,
	input wire logic        o_spi_mosi,
	input wire logic [3:0]  i_spi_dq,
	// Link
	input wire logic        i_link_clk,
	input wire logic        i_link_en,
	input wire logic [31:0] i_link_data,
	input wire logic        o_link_ready,
	// User side
	input wire logic        o_cfg_done,
	input wire logic        o_cfg_busy,
	input wire logic [9:0]  i_cfg_rd_addr,
	input wire logic [31:0] o_cfg_rd_data
);
	logic [9:0] lo_ff, hi_ff;
	logic [1:0] frm_ff;
	logic       cs_d_ff;

	// Length of the current select-low run
	always_ff @(posedge i_sys_clk or negedge i_rstn)
		if (!i_rstn) lo_ff <= 10'h000;
		else lo_ff <= o_spi_cs_n ? 10'h000 : lo_ff + 10'h001;

	// Length of the current idle run, saturating
	always_ff @(posedge i_sys_clk or negedge i_rstn)
		if (!i_rstn) hi_ff <= 10'h000;
		else if (!o_spi_cs_n) hi_ff <= 10'h000;
		else if (hi_ff != 10'h3FF) hi_ff <= hi_ff + 10'h001;

	// Frames since the last start
	always_ff @(posedge i_sys_clk or negedge i_rstn)
		if (!i_rstn) cs_d_ff <= 1'b1;
		else cs_d_ff <= o_spi_cs_n;
	always_ff @(posedge i_sys_clk or negedge i_rstn)
		if (!i_rstn) frm_ff <= 2'h0;
		else if (!i_config_reset_n) frm_ff <= 2'h0;
		else if (cs_d_ff && !o_spi_cs_n && frm_ff != 2'h3)
			frm_ff <= frm_ff + 2'h1;

	start_wake_a: assert property (@(posedge i_sys_clk)
		disable iff (!i_rstn)
		$rose(i_config_reset_n) && i_mode == 2'h0 |-> ##[1:6] !o_spi_cs_n)
		else $error("flash not selected after start");
	// Eight clock periods less the select setup cycle
	wake_len_a: assert property (@(posedge i_sys_clk)
		disable iff (!i_rstn)
		$rose(o_spi_cs_n) && frm_ff == 2'h1 && i_config_reset_n
		|-> lo_ff == 10'd31)
		else $error("wake frame length wrong");
	wake_gap_a: assert property (@(posedge i_sys_clk)
		disable iff (!i_rstn)
		$fell(o_spi_cs_n) && frm_ff == 2'h1 |-> hi_ff >= 10'd300)
		else $error("read issued too soon after wake");
	sck_high_a: assert property (@(posedge i_sys_clk)
		disable iff (!i_rstn)
		$rose(o_spi_sck) && i_config_reset_n |=> o_spi_sck ##1 !o_spi_sck)
		else $error("flash clock high time wrong");
	sck_low_a: assert property (@(posedge i_sys_clk)
		disable iff (!i_rstn)
		$fell(o_spi_sck) |=> !o_spi_sck)
		else $error("flash clock low time wrong");
	sck_idle_a: assert property (@(posedge i_sys_clk)
		disable iff (!i_rstn)
		o_spi_cs_n |-> !o_spi_sck)
		else $error("flash clock runs while deselected");
	done_after_a: assert property (@(posedge i_sys_clk)
		disable iff (!i_rstn)
		$rose(o_cfg_done) |-> $past(o_cfg_busy))
		else $error("done without a load");
	sel_kept_a: assert property (@(posedge i_sys_clk)
		disable iff (!i_rstn)
		$rose(o_cfg_done) && i_mode == 2'h0 |-> $past(o_spi_cs_n) == 1'b0)
		else $error("flash deselected before load end");
	abort_a: assert property (@(posedge i_sys_clk)
		disable iff (!i_rstn)
		!i_config_reset_n [*4] |-> o_spi_cs_n && !o_spi_sck && !o_cfg_busy)
		else $error("load not aborted");
	link_word_a: assert property (@(posedge i_link_clk)
		disable iff (!i_rstn)
		i_link_en && o_link_ready && i_mode == 2'h1 && i_width == 3'h5
		|=> !o_link_ready)
		else $error("link slot not closed after word");

	// Completed loads per source
	cover property (@(posedge i_sys_clk) $rose(o_cfg_done) && i_mode == 2'h0);
	cover property (@(posedge i_sys_clk) $rose(o_cfg_done) && i_mode == 2'h1);
	cover property (@(posedge i_sys_clk) $rose(o_cfg_done) && i_mode == 2'h3);
endmodule // fcl_loader_chk

bind fcl_loader fcl_loader_chk #(.CFG_WORDS(CFG_WORDS)) fcl_loader_chk_inst
(
	.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
	.i_config_reset_n(i_config_reset_n), .i_mode(i_mode),
	.i_width(i_width), .o_spi_sck(o_spi_sck), .o_spi_cs_n(o_spi_cs_n),
	.o_spi_mosi(o_spi_mosi), .i_spi_dq(i_spi_dq), .i_link_clk(i_link_clk),
	.i_link_en(i_link_en), .i_link_data(i_link_data),
	.o_link_ready(o_link_ready), .o_cfg_done(o_cfg_done),
	.o_cfg_busy(o_cfg_busy), .i_cfg_rd_addr(i_cfg_rd_addr),
	.o_cfg_rd_data(o_cfg_rd_data)
);

// ==== fcl_loader_test.sv ====
// Self-checking bench for the configuration loader
`timescale 1ns/1ps
module fcl_loader_test;
	localparam int NW = 8;
	logic        clk, rstn, crn, lclk, lrun, en, rdy;
	logic        sck, cs_n, mosi, done, busy;
	logic [1:0]  mode;
	logic [2:0]  width, fwc;
	logic [3:0]  dq;
	logic [7:0]  wake;
	logic [9:0]  ra;
	logic [31:0] ld, rdata, rcmd, gap;
	logic [31:0] lw [NW];
	int          errors, cmp_count, c, k;

	fcl_loader #(.CFG_WORDS(NW)) fcl_loader_inst
	(
		.i_sys_clk(clk), .i_rstn(rstn), .i_config_reset_n(crn),
		.i_mode(mode), .i_width(width), .o_spi_sck(sck),
		.o_spi_cs_n(cs_n), .o_spi_mosi(mosi), .i_spi_dq(dq),
		.i_link_clk(lclk), .i_link_en(en), .i_link_data(ld),
		.o_link_ready(rdy), .o_cfg_done(done), .o_cfg_busy(busy),
		.i_cfg_rd_addr(ra), .o_cfg_rd_data(rdata)
	);

	fcl_flash_model fcl_flash_model_inst
	(
		.i_sck(sck), .i_cs_n(cs_n), .i_mosi(mosi), .o_dq(dq),
		.i_wc(fwc), .o_wake(wake), .o_rcmd(rcmd), .o_gap(gap)
	);

	// System clock, and a link clock that runs only in link loads
	always #50 clk = ~clk;
	always #24 if (lrun) lclk = ~lclk;

	// Flash contents as the model holds them
	function automatic logic [31:0] fw(input int j);
		return {4{j[7:0]}} ^ 32'hA5C3_0F96;
	endfunction

	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task wrap_up;
		if (errors == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Pulse the configuration reset pin with the straps set
	task start(input logic [1:0] m, input logic [2:0] wc);
		@(posedge clk);
		mode <= m;
		width <= wc;
		crn <= 1'b0;
		repeat (4) @(posedge clk);
		crn <= 1'b1;
		// Busy before any link word or flash word can finish
		repeat (8) @(negedge clk);
		chk({31'h0, busy}, 32'h1);
		chk({31'h0, done}, 32'h0);
	endtask

	task wait_done;
		int i;
		for (i = 0; i < 20000 && done !== 1'b1; i++)
			@(negedge clk);
		chk({31'h0, done}, 32'h1);
	endtask

	// Read all words back: 0 flash, 1 link, 2 mask ROM
	task readback(input int kind);
		int j;
		for (j = 0; j < NW; j++)
		begin
			@(posedge clk);
			ra <= j[9:0];
			repeat (2) @(posedge clk);
			@(negedge clk);
			chk(rdata, kind == 0 ? fw(j) : kind == 1 ? lw[j] :
				fcl_pkg::ROM_FILL ^ 32'(j));
		end
	endtask

	// One word as w-bit beats, junk above the used lines
	task send_word(input logic [31:0] wd, input int w);
		int b, g;
		logic r;
		logic [31:0] v;
		@(posedge lclk);
		for (b = 0; b < 32 / w; b++)
		begin
			v = ($urandom << w) | ((wd << (b * w)) >> (32 - w));
			ld <= v;
			en <= 1'b1;
			g = 0;
			do
			begin
				@(negedge lclk);
				r = rdy;
				@(posedge lclk);
				g++;
			end while (r !== 1'b1 && g < 500);
		end
		en <= 1'b0;
	endtask

	initial
	begin
		clk = 0; lclk = 0; lrun = 0; rstn = 0; crn = 1; mode = 0;
		width = 0; en = 0; ld = 0; ra = 0; fwc = 0;
		errors = 0; cmp_count = 0;
		void'($urandom(58));
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		@(negedge clk);
		chk({30'h0, cs_n, busy | done}, 32'h2);
		// Flash loads at x1, x2, x4 and a clamped x8
		for (c = 0; c < 4; c++)
		begin
			fwc = c > 2 ? 3'h2 : c[2:0];
			start(2'h0, c[2:0]);
			wait_done();
			chk({24'h0, wake}, {24'h0, fcl_pkg::CMD_WAKE});
			chk(rcmd, {fcl_pkg::CMD_FAST_READ, fcl_pkg::START_ADDR});
			chk({31'h0, gap >= 32'(fcl_pkg::WAKE_WAIT_NS)}, 32'h1);
			readback(0);
		end
		// Abort a flash load at a random point and start over
		fwc = 3'h2;
		start(2'h0, 3'h2);
		repeat (100 + $urandom % 900) @(posedge clk);
		fwc = 3'h1;
		start(2'h0, 3'h1);
		wait_done();
		readback(0);
		// Link loads at every width, then the test port at x1
		lrun = 1;
		for (c = 0; c < 7; c++)
		begin
			start(c < 6 ? 2'h1 : 2'h2, c < 6 ? c[2:0] : 3'($urandom % 6));
			for (k = 0; k < NW; k++)
			begin
				lw[k] = $urandom;
				send_word(lw[k], c < 6 ? 1 << c : 1);
			end
			wait_done();
			readback(1);
		end
		lrun = 0;
		start(2'h3, 3'h0);
		wait_done();
		readback(2);
		wrap_up();
	end

	// Watchdog: several times the expected run length
	initial
	begin
		#6000000;
		errors++;
		wrap_up();
	end
endmodule // fcl_loader_test
